// File: hw/tmr_timer.sv
// Multichannel timer core with register slave, counter and channels.
// Assumes AXI4-Lite master on clk; pins synchronous to clk.
`timescale 1ns/1ps
`include "tmr_defines.svh"

// What this block does
// - Widest build: 32-bit auto-reload counter, up, down or center, 32-bit prescaler.
// - Narrow build counts up only, 16-bit, prescaler divides by 1 to 65536.
// - Four independent channels: capture, compare or PWM each; one-pulse mode stops the shared counter.
// - Edge- and center-aligned PWM, duty from constant low to constant high.
// - Complementary pairs with programmable dead time between partner edges.
// - Three-phase use over six lines: three channels plus their complements.
// - Debug halt can freeze the counter and force outputs inactive.
// - Trigger input starts, clocks or resets; update drives trigger output.
// - Own DMA requests for update and each channel event.
// - Encoder mode: two quadrature inputs step the counter up or down.
// - Builds with two channels plus one complement keep all modes; a one-channel build reads both encoder inputs from chIn[0].
module tmr_timer #(
  parameter int W         = 32,
  parameter int NUM_CH    = 4,
  parameter int NUM_COMPL = 3,
  parameter bit UPDOWN    = 1'b1
) (
  // Clock and reset
  input  logic                      clk,
  input  logic                      nrst,
  // Register bus
  input  tmr_pkg::tmr_axi_req_type  axiReq,
  output tmr_pkg::tmr_axi_rsp_type  axiRsp,
  // Channel pins
  input  logic [NUM_CH-1:0]         chIn,
  output logic [NUM_CH-1:0]         chOut,
  output logic [NUM_CH-1:0]         chOutN,
  output logic [NUM_CH-1:0]         chOe,
  // Timer link and debug
  input  logic                      trigIn,
  output logic                      trigOut,
  input  logic                      dbgHalt,
  // Service requests
  output logic                      irq,
  output logic [NUM_CH:0]           dmaReq
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (!(W == 16 || W == 32) || NUM_CH < 1 || NUM_CH > 4 || NUM_COMPL > NUM_CH) begin : g_bad
    $error("Unsupported timer parameters");
  end

  localparam int ENC_B = (NUM_CH > 1) ? 1 : 0;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [`TMR_CTRL_W-1:0]                ctrl;
    logic [W-1:0]                          presc;
    logic [W-1:0]                          reload;
    logic [W-1:0]                          cnt;
    logic [W-1:0]                          psc;
    logic                                  down;
    logic [NUM_CH:0]                       sts;
    logic [NUM_CH:0]                       mask;
    logic [NUM_CH:0]                       dmaEn;
    logic [NUM_CH:0]                       dma;
    logic [`TMR_DEAD_W-1:0]                dead;
    tmr_pkg::tmr_chcfg_type [NUM_CH-1:0]   cfg;
    logic [NUM_CH-1:0][W-1:0]              ccv;
    logic                                  trigPrev;
    logic                                  encA;
    logic                                  encB;
    logic                                  trigOut;
    logic                                  awGot;
    logic                                  wGot;
    logic                                  bvalid;
    logic                                  rvalid;
    logic [1:0]                            bresp;
    logic [1:0]                            rresp;
    logic [7:0]                            awAddr;
    logic [31:0]                           wData;
    logic [31:0]                           rdata;
    logic [3:0]                            wStrb;
  } tmr_state_type;

  tmr_state_type             q;
  tmr_state_type             d;
  tmr_pkg::tmr_dir_type      dir;
  tmr_pkg::tmr_tsel_type     tsel;
  logic [NUM_CH-1:0][W-1:0]  chCap;
  logic [NUM_CH-1:0]         chEvt;
  logic                      frz;
  logic                      outEn;
  logic                      trigEdge;
  logic                      encEdge;
  logic                      encDown;
  logic                      srcTick;
  logic                      pscTick;
  logic                      step;
  logic                      center;
  logic                      down;
  logic                      commitW;

  // ****************************************
  // Count control
  // ****************************************
  assign dir      = tmr_pkg::tmr_dir_type'(q.ctrl[`TMR_DIR +: 2]);
  assign tsel     = tmr_pkg::tmr_tsel_type'(q.ctrl[`TMR_TSEL +: 2]);
  assign frz      = dbgHalt & q.ctrl[`TMR_FRZ];
  assign outEn    = q.ctrl[`TMR_MOE] & ~(dbgHalt & q.ctrl[`TMR_DOFF]);
  assign trigEdge = trigIn & ~q.trigPrev;
  assign encEdge  = (chIn[0] ^ q.encA) | (chIn[ENC_B] ^ q.encB);
  // Phase order decides direction
  assign encDown  = (chIn[0] ^ q.encA) ? (chIn[0] == chIn[ENC_B]) : (chIn[ENC_B] != chIn[0]);
  assign srcTick  = (tsel == tmr_pkg::TS_CLOCK) ? trigEdge : 1'b1;
  // At or above, so a smaller divider written mid-count cannot strand the count
  assign pscTick  = srcTick && (q.psc >= q.presc);
  assign step     = q.ctrl[`TMR_EN] && !frz && (q.ctrl[`TMR_ENC] && UPDOWN ? encEdge : pscTick);
  assign center   = UPDOWN && dir == tmr_pkg::DIR_CENTER && !q.ctrl[`TMR_ENC];
  // Narrow builds only count up
  assign down     = UPDOWN && (q.ctrl[`TMR_ENC] ? encDown : center ? q.down : dir == tmr_pkg::DIR_DOWN);
  assign commitW  = q.awGot & q.wGot;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Top bit flags a mapped address
  function automatic logic [32:0] rdMux(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (a)
      `TMR_OFF_CTRL:   r[31:0] = 32'(q.ctrl);
      `TMR_OFF_PRESC:  r[31:0] = 32'(q.presc);
      `TMR_OFF_RELOAD: r[31:0] = 32'(q.reload);
      `TMR_OFF_COUNT:  r[31:0] = 32'(q.cnt);
      `TMR_OFF_STATUS: r[31:0] = 32'(q.sts);
      `TMR_OFF_MASK:   r[31:0] = 32'(q.mask);
      `TMR_OFF_DMAEN:  r[31:0] = 32'(q.dmaEn);
      `TMR_OFF_DEAD:   r[31:0] = 32'(q.dead);
      default: begin
        r[32] = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
          if (a == `TMR_OFF_CHCFG + 8'(i) * `TMR_CH_STRIDE) begin
            r = {1'b1, 32'(q.cfg[i])};
          end
          if (a == `TMR_OFF_CCVAL + 8'(i) * `TMR_CH_STRIDE) begin
            r = {1'b1, 32'(q.cfg[i].mode == tmr_pkg::CH_CAPTURE ? chCap[i] : q.ccv[i])};
          end
        end
      end
    endcase
    return r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic        upd;
    logic [7:0]  wa;
    logic [32:0] rw;
    logic [31:0] wv;
    upd        = 1'b0;
    wa         = {q.awAddr[7:2], 2'b00};
    rw         = rdMux(wa);
    wv         = merge(rw[31:0], q.wData, q.wStrb);
    d          = q;
    d.trigPrev = trigIn;
    d.encA     = chIn[0];
    d.encB     = chIn[ENC_B];
    if (q.ctrl[`TMR_EN] && !frz && srcTick) begin
      d.psc = pscTick ? '0 : q.psc + 1'b1;
    end
    if (step) begin
      if (!down) begin
        if (q.cnt >= q.reload) begin
          upd = 1'b1;
          if (center) begin
            d.cnt  = q.reload - 1'b1;
            d.down = 1'b1;
          end else begin
            d.cnt = '0;
          end
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end else begin
        if (q.cnt == '0) begin
          upd = 1'b1;
          if (center) begin
            d.cnt  = W'(1);
            d.down = 1'b0;
          end else begin
            d.cnt = q.reload;
          end
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
    end
    if (tsel == tmr_pkg::TS_RESET && trigEdge && !frz) begin
      d.cnt = '0;
      upd   = 1'b1;
    end
    if (tsel == tmr_pkg::TS_START && trigEdge) begin
      d.ctrl[`TMR_EN] = 1'b1;
    end
    // One-pulse: the update that ends the pulse stops the counter
    if (upd && q.ctrl[`TMR_OPM]) begin
      d.ctrl[`TMR_EN] = 1'b0;
    end
    d.trigOut = upd;
    d.dma     = {chEvt, upd} & q.dmaEn;

    // Register bus
    if (axiReq.awvalid && !q.awGot && !q.bvalid) begin
      d.awGot  = 1'b1;
      d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !q.wGot && !q.bvalid) begin
      d.wGot  = 1'b1;
      d.wData = axiReq.wdata;
      d.wStrb = axiReq.wstrb;
    end
    if (q.bvalid && axiReq.bready) begin
      d.bvalid = 1'b0;
    end
    if (commitW) begin
      d.awGot  = 1'b0;
      d.wGot   = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = rw[32] ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      case (wa)
        `TMR_OFF_CTRL:   d.ctrl   = wv[`TMR_CTRL_W-1:0];
        `TMR_OFF_PRESC:  d.presc  = wv[W-1:0];
        `TMR_OFF_RELOAD: d.reload = wv[W-1:0];
        `TMR_OFF_COUNT:  d.cnt    = wv[W-1:0];
        `TMR_OFF_MASK:   d.mask   = wv[NUM_CH:0];
        `TMR_OFF_DMAEN:  d.dmaEn  = wv[NUM_CH:0];
        `TMR_OFF_DEAD:   d.dead   = wv[`TMR_DEAD_W-1:0];
        default: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (wa == `TMR_OFF_CHCFG + 8'(i) * `TMR_CH_STRIDE) begin
              d.cfg[i] = tmr_pkg::tmr_chcfg_type'(wv[3:0]);
            end
            if (wa == `TMR_OFF_CCVAL + 8'(i) * `TMR_CH_STRIDE) begin
              d.ccv[i] = wv[W-1:0];
            end
          end
        end
      endcase
    end
    if (q.rvalid && axiReq.rready) begin
      d.rvalid = 1'b0;
    end
    if (axiReq.arvalid && !q.rvalid) begin
      rw       = rdMux({axiReq.araddr[7:2], 2'b00});
      d.rvalid = 1'b1;
      d.rdata  = rw[31:0];
      d.rresp  = rw[32] ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      if ({axiReq.araddr[7:2], 2'b00} == `TMR_OFF_STATUS) begin
        d.sts = '0;
      end
    end
    // Events after the read clear, so a new event is never lost
    d.sts = d.sts | {chEvt, upd};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q        <= '0;
      q.ctrl   <= `TMR_CTRL_RST;
      q.reload <= '1;
      q.dead   <= `TMR_DEAD_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  // Channels below NUM_COMPL get a complement: three pairs give six phase lines
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    tmr_channel #(
      .W     (W),
      .COMPL (c < NUM_COMPL)
    ) u_ch (
      .clk      (clk),
      .nrst     (nrst),
      .cfg      (q.cfg[c]),
      .ccVal    (q.ccv[c]),
      .count    (q.cnt),
      .step     (step),
      .deadTime (q.dead),
      .outEn    (outEn),
      .pin      (chIn[c]),
      .capVal   (chCap[c]),
      .evt      (chEvt[c]),
      .out      (chOut[c]),
      .outN     (chOutN[c]),
      .oe       (chOe[c])
    );
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign axiRsp = '{awready: ~q.awGot & ~q.bvalid,
                    wready:  ~q.wGot & ~q.bvalid,
                    bvalid:  q.bvalid,
                    bresp:   q.bresp,
                    arready: ~q.rvalid,
                    rvalid:  q.rvalid,
                    rdata:   q.rdata,
                    rresp:   q.rresp};
  assign trigOut = q.trigOut;
  assign dmaReq  = q.dma;
  assign irq     = |(q.sts & q.mask);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_wrap_up;
    (step && !down && !center && q.cnt >= q.reload && !commitW && tsel != tmr_pkg::TS_RESET)
      |=> (q.cnt == '0 && q.trigOut && q.sts[0]);
  endproperty
  a_wrap_up: assert property (p_wrap_up)
    else $error("Overflow did not wrap and flag update");

  property p_down_reload;
    (step && down && !center && q.cnt == '0 && !commitW && tsel != tmr_pkg::TS_RESET)
      |=> (q.cnt == $past(q.reload));
  endproperty
  a_down_reload: assert property (p_down_reload)
    else $error("Underflow did not reload");

  property p_presc;
    (q.ctrl[`TMR_EN] && !frz && srcTick && q.psc < q.presc) |=> (q.psc == $past(q.psc) + 1'b1);
  endproperty
  a_presc: assert property (p_presc)
    else $error("Prescaler did not advance");

  property p_freeze;
    (frz && !commitW) |=> (q.cnt == $past(q.cnt));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Counter moved while frozen");

  property p_outs_off;
    (dbgHalt && q.ctrl[`TMR_DOFF]) [*2] |-> (chOut == '0 && chOutN == '0);
  endproperty
  a_outs_off: assert property (p_outs_off)
    else $error("Outputs active in debug halt");

  property p_link;
    (tsel == tmr_pkg::TS_START && trigEdge && !commitW && !step) |=> q.ctrl[`TMR_EN];
  endproperty
  a_link: assert property (p_link)
    else $error("Trigger input did not start counter");

  property p_dma;
    (q.trigOut && $past(q.dmaEn[0])) |-> dmaReq[0];
  endproperty
  a_dma: assert property (p_dma)
    else $error("Update DMA request missing");

  property p_enc;
    (q.ctrl[`TMR_EN] && q.ctrl[`TMR_ENC] && !frz && !commitW && !trigEdge && chIn[0] && !q.encA
      && !chIn[ENC_B] && !q.encB && q.cnt < q.reload) |=> (q.cnt == $past(q.cnt) + 1'b1);
  endproperty
  a_enc: assert property (p_enc)
    else $error("Encoder step not counted up");

endmodule

// File: include/tmr_defines.svh
// Register map, field positions and reset values of the timer.
// Assumes byte addresses on an 8-bit register bus address.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define TMR_OFF_CTRL   8'h00
`define TMR_OFF_PRESC  8'h04
`define TMR_OFF_RELOAD 8'h08
`define TMR_OFF_COUNT  8'h0C
`define TMR_OFF_STATUS 8'h10
`define TMR_OFF_MASK   8'h14
`define TMR_OFF_DMAEN  8'h18
`define TMR_OFF_DEAD   8'h1C
`define TMR_OFF_CHCFG  8'h20
`define TMR_OFF_CCVAL  8'h30
`define TMR_CH_STRIDE  8'h04

// ****************************************
// Control fields and widths
// ****************************************
`define TMR_EN     0
`define TMR_DIR    1
`define TMR_OPM    3
`define TMR_FRZ    4
`define TMR_DOFF   5
`define TMR_ENC    6
`define TMR_TSEL   8
`define TMR_MOE    10
`define TMR_CTRL_W 11
`define TMR_DEAD_W 8

// ****************************************
// Reset values and responses
// ****************************************
`define TMR_CTRL_RST    11'h000
`define TMR_DEAD_RST    8'h00
`define TMR_RESP_OKAY   2'h0
`define TMR_RESP_SLVERR 2'h2

`endif

// File: include/tmr_pkg.sv
// Types shared by the timer core and its channels.
// Assumes nothing of its surroundings.
package tmr_pkg;

  typedef enum logic [1:0] {DIR_UP, DIR_DOWN, DIR_CENTER, DIR_SPARE} tmr_dir_type;
  typedef enum logic [1:0] {CH_COMPARE, CH_PWM, CH_CAPTURE, CH_OFF} tmr_chmode_type;
  typedef enum logic [1:0] {TS_NONE, TS_START, TS_CLOCK, TS_RESET} tmr_tsel_type;

  typedef struct packed {
    logic           compl;
    logic           fallEdge;
    tmr_chmode_type mode;
  } tmr_chcfg_type;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } tmr_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tmr_axi_rsp_type;

endpackage

// File: hw/tmr_channel.sv
// One capture/compare channel with dead-time output pair.
// Assumes count and step come from the timer core, same clock.
`timescale 1ns/1ps
`include "tmr_defines.svh"

module tmr_channel #(
  parameter int W     = 32,
  parameter bit COMPL = 1'b0
) (
  // Clock and reset
  input  logic                     clk,
  input  logic                     nrst,
  // Setup from the core
  input  tmr_pkg::tmr_chcfg_type   cfg,
  input  logic [W-1:0]             ccVal,
  input  logic [W-1:0]             count,
  input  logic                     step,
  input  logic [`TMR_DEAD_W-1:0]   deadTime,
  input  logic                     outEn,
  // Pin and results
  input  logic                     pin,
  output logic [W-1:0]             capVal,
  output logic                     evt,
  output logic                     out,
  output logic                     outN,
  output logic                     oe
);

  typedef struct packed {
    logic [W-1:0]             cap;
    logic                     pinPrev;
    logic                     refLvl;
    logic [`TMR_DEAD_W-1:0]   dt;
    logic                     out;
    logic                     outN;
    logic                     oe;
    logic                     evt;
  } tmr_chst_type;

  tmr_chst_type q;
  tmr_chst_type d;
  logic         edgeSeen;
  logic         hit;

  assign edgeSeen = cfg.fallEdge ? (q.pinPrev & ~pin) : (~q.pinPrev & pin);
  assign hit      = step && (count == ccVal);

  always_comb begin
    d         = q;
    d.evt     = 1'b0;
    d.pinPrev = pin;
    unique case (cfg.mode)
      tmr_pkg::CH_CAPTURE: begin
        d.refLvl = 1'b0;
        if (edgeSeen) begin
          d.cap = count;
          d.evt = 1'b1;
        end
      end
      tmr_pkg::CH_PWM: begin
        d.refLvl = count < ccVal;
        d.evt    = hit;
      end
      tmr_pkg::CH_COMPARE: begin
        if (hit) begin
          d.refLvl = ~q.refLvl;
          d.evt    = 1'b1;
        end
      end
      tmr_pkg::CH_OFF: d.refLvl = 1'b0;
    endcase
    // Forced inactive rather than released, so switches see a low level
    d.oe = cfg.mode == tmr_pkg::CH_COMPARE || cfg.mode == tmr_pkg::CH_PWM;
    // Break before make on every edge of the reference
    if (d.refLvl != q.refLvl && deadTime != `TMR_DEAD_RST) begin
      d.dt   = deadTime;
      d.out  = 1'b0;
      d.outN = 1'b0;
    end else if (q.dt != `TMR_DEAD_RST) begin
      d.dt   = q.dt - 8'h01;
      d.out  = 1'b0;
      d.outN = 1'b0;
    end else begin
      d.out  = d.refLvl & d.oe & outEn;
      d.outN = COMPL & cfg.compl & ~d.refLvl & d.oe & outEn;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign capVal = q.cap;
  assign evt    = q.evt;
  assign out    = q.out;
  assign outN   = q.outN;
  assign oe     = q.oe;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_no_overlap;
    !(q.out && q.outN);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("Both outputs of a pair active");

  property p_dead_gap;
    ($changed(q.refLvl) && $past(deadTime) != 8'h00) |-> (!q.out && !q.outN) [*2];
  endproperty
  a_dead_gap: assert property (p_dead_gap)
    else $error("Dead time not inserted");

  property p_capture;
    (cfg.mode == tmr_pkg::CH_CAPTURE && edgeSeen) |=> (q.cap == $past(count) && q.evt);
  endproperty
  a_capture: assert property (p_capture)
    else $error("Capture did not latch count");

  property p_pwm_duty;
    (cfg.mode == tmr_pkg::CH_PWM) |=> (q.refLvl == ($past(count) < $past(ccVal)));
  endproperty
  a_pwm_duty: assert property (p_pwm_duty)
    else $error("PWM level wrong for compare value");

endmodule

// File: testbench/tmr_switch_model.sv
// Power switch stage and external signal source on the timer pins.
// Assumes pins are synchronous to clk; the bench sets the input levels.
`timescale 1ns/1ps

module tmr_switch_model (
  // Clock
  input  logic       clk,
  // Timer pins
  input  logic [3:0] chOut,
  input  logic [3:0] chOutN,
  input  logic [3:0] chOe,
  output logic [3:0] chIn,
  // Bench side
  input  logic [3:0] sigLevel,
  output logic [7:0] faults,
  output logic [7:0] gap,
  output logic [3:0] seenN
);
  logic [7:0] runLow;

  initial begin
    chIn = 4'h0;
    faults = 8'h00;
    gap = 8'h00;
    seenN = 4'h0;
    runLow = 8'h00;
  end

  // Both switches of a leg on at once would short the supply
  always @(posedge clk) begin
    chIn <= sigLevel;
    seenN <= seenN | chOutN;
    if (|(chOut & chOutN & chOe)) faults <= faults + 8'h01;
    if (chOut[0] | chOutN[0]) begin
      if (runLow != 8'h00) gap <= runLow;
      runLow <= 8'h00;
    end else begin
      runLow <= runLow + 8'h01;
    end
  end
endmodule

// File: testbench/tmr_timer_bench.sv
// Self-checking bench of the timer core: register bus, counter, channels.
// Assumes the switch model stands on the channel pins.
`timescale 1ns/1ps
`include "tmr_defines.svh"

module tmr_timer_bench;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} tmr_rdexp_type;
  logic                     clk;
  logic                     nrst;
  tmr_pkg::tmr_axi_req_type req;
  tmr_pkg::tmr_axi_rsp_type rsp;
  logic [3:0]               chIn, chOut, chOutN, chOe, sigLevel, seenN;
  logic                     trigIn, trigOut, dbgHalt, irq;
  logic [4:0]               dmaReq;
  logic [7:0]               faults, gap;
  tmr_rdexp_type            expQ[$];
  tmr_rdexp_type            e;
  int                       n_mismatch = 0;
  int                       cmp_count = 0;
  logic [15:0]              lfsr = 16'hAF36;
  logic [31:0]              v;
  logic [7:0]               rAdr [6] = '{`TMR_OFF_PRESC, `TMR_OFF_RELOAD, `TMR_OFF_MASK, `TMR_OFF_DMAEN,
                                         `TMR_OFF_DEAD, `TMR_OFF_CCVAL};
  logic [31:0]              rMsk [6] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h1F, 32'h1F, 32'hFF, 32'hFFFFFFFF};

  tmr_timer tmr_timer_inst (.clk(clk), .nrst(nrst), .axiReq(req), .axiRsp(rsp), .chIn(chIn), .chOut(chOut),
    .chOutN(chOutN), .chOe(chOe), .trigIn(trigIn), .trigOut(trigOut), .dbgHalt(dbgHalt), .irq(irq), .dmaReq(dmaReq));
  tmr_switch_model tmr_switch_model_inst (.clk(clk), .chOut(chOut), .chOutN(chOutN), .chOe(chOe), .chIn(chIn),
    .sigLevel(sigLevel), .faults(faults), .gap(gap), .seenN(seenN));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] nextRand(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    check("bresp", {30'h0, r}, {30'h0, rsp.bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    @(posedge clk);
    expQ.push_back('{d & m, m, r});
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
  endtask

  // Cycles between two trigger pulses, with the update requests seen up to and including the second
  task automatic period(input int exp);
    int n, d;
    n = 0;
    d = 0;
    do begin
      @(posedge clk);
      n++;
    end while (trigOut !== 1'b1 && n < 400);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (dmaReq[0] === 1'b1) d++;
    end while (trigOut !== 1'b1 && n < 400);
    check("period", exp, n);
    check("dmaUpdate", 1, d);
  endtask

  task automatic highs(input int exp);
    int n;
    n = 0;
    repeat (12) @(posedge clk);
    repeat (20) begin
      @(posedge clk);
      if (chOut[0] === 1'b1) n++;
    end
    check("duty", exp, n);
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Read data checker
  // ****************************************
  always @(posedge clk) begin
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1 && expQ.size() > 0) begin
      e = expQ.pop_front();
      check("rdata", e.d, rsp.rdata & e.m);
      check("rresp", {30'h0, e.r}, {30'h0, rsp.rresp});
    end
  end

  initial begin
    #750000;
    n_mismatch++;
    report_and_stop();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    req = '0;
    nrst = 1'b0;
    sigLevel = 4'h0;
    trigIn = 1'b0;
    dbgHalt = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) rd(8'(i * 4), (i == 2) ? 32'hFFFFFFFF : 32'h0, '1, `TMR_RESP_OKAY);
    rd(8'hFC, 32'h0, '1, `TMR_RESP_SLVERR);
    wr(8'hFC, 32'h1, `TMR_RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      lfsr = nextRand(lfsr);
      v[31:16] = lfsr;
      lfsr = nextRand(lfsr);
      v[15:0] = lfsr;
      wr(rAdr[i], v, `TMR_RESP_OKAY);
      rd(rAdr[i], v & rMsk[i], '1, `TMR_RESP_OKAY);
    end
    wr(`TMR_OFF_MASK, 32'h0, `TMR_RESP_OKAY);
    wr(`TMR_OFF_DMAEN, 32'h1, `TMR_RESP_OKAY);
    wr(`TMR_OFF_RELOAD, 32'h5, `TMR_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(`TMR_OFF_PRESC, 32'(i), `TMR_RESP_OKAY);
      wr(`TMR_OFF_CTRL, 32'h1 | 32'(i << 1), `TMR_RESP_OKAY);
      period((i + 1) * ((i == 2) ? 5 : 6));
    end
    check("irqMasked", 1'b0, irq);
    wr(`TMR_OFF_MASK, 32'h1, `TMR_RESP_OKAY);
    @(posedge clk);
    check("irqSet", 1'b1, irq);
    wr(`TMR_OFF_CTRL, 32'h0, `TMR_RESP_OKAY);
    rd(`TMR_OFF_STATUS, 32'h1, 32'h1, `TMR_RESP_OKAY);
    rd(`TMR_OFF_STATUS, 32'h0, 32'h1, `TMR_RESP_OKAY);
    repeat (2) @(posedge clk);
    check("irqClear", 1'b0, irq);
    wr(`TMR_OFF_CHCFG + 8'h04, 32'h2, `TMR_RESP_OKAY);
    wr(`TMR_OFF_COUNT, 32'h1234, `TMR_RESP_OKAY);
    sigLevel[1] <= 1'b1;
    repeat (6) @(posedge clk);
    rd(`TMR_OFF_CCVAL + 8'h04, 32'h1234, '1, `TMR_RESP_OKAY);
    rd(`TMR_OFF_STATUS, 32'h4, 32'h4, `TMR_RESP_OKAY);
    wr(`TMR_OFF_CHCFG + 8'h04, 32'h6, `TMR_RESP_OKAY);
    wr(`TMR_OFF_COUNT, 32'h55, `TMR_RESP_OKAY);
    sigLevel[1] <= 1'b0;
    repeat (6) @(posedge clk);
    rd(`TMR_OFF_CCVAL + 8'h04, 32'h55, '1, `TMR_RESP_OKAY);
    wr(`TMR_OFF_DEAD, 32'h0, `TMR_RESP_OKAY);
    wr(`TMR_OFF_PRESC, 32'h0, `TMR_RESP_OKAY);
    wr(`TMR_OFF_RELOAD, 32'h9, `TMR_RESP_OKAY);
    wr(`TMR_OFF_CHCFG, 32'h1, `TMR_RESP_OKAY);
    wr(`TMR_OFF_CCVAL, 32'h0, `TMR_RESP_OKAY);
    wr(`TMR_OFF_CTRL, 32'h401, `TMR_RESP_OKAY);
    highs(0);
    wr(`TMR_OFF_CCVAL, 32'h14, `TMR_RESP_OKAY);
    highs(20);
    wr(`TMR_OFF_DEAD, 32'h3, `TMR_RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      wr(`TMR_OFF_CCVAL + 8'(i * 4), 32'h5, `TMR_RESP_OKAY);
      wr(`TMR_OFF_CHCFG + 8'(i * 4), 32'h9, `TMR_RESP_OKAY);
    end
    repeat (40) @(posedge clk);
    check("deadGap", 32'h4, {24'h0, gap});
    check("shootThrough", 32'h0, {24'h0, faults});
    check("complLines", 32'h7, {28'h0, seenN});
    wr(`TMR_OFF_CTRL, 32'h431, `TMR_RESP_OKAY);
    dbgHalt <= 1'b1;
    wr(`TMR_OFF_COUNT, 32'h7, `TMR_RESP_OKAY);
    repeat (10) @(posedge clk);
    rd(`TMR_OFF_COUNT, 32'h7, '1, `TMR_RESP_OKAY);
    check("haltOut", 32'h0, {24'h0, chOut, chOutN});
    dbgHalt <= 1'b0;
    wr(`TMR_OFF_CTRL, 32'h441, `TMR_RESP_OKAY);
    wr(`TMR_OFF_COUNT, 32'h0, `TMR_RESP_OKAY);
    for (int i = 1; i < 5; i++) begin
      sigLevel[1:0] <= 2'((i & 3) ^ ((i & 3) >> 1));
      repeat (3) @(posedge clk);
    end
    rd(`TMR_OFF_COUNT, 32'h4, '1, `TMR_RESP_OKAY);
    wr(`TMR_OFF_CTRL, 32'h500, `TMR_RESP_OKAY);
    trigIn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`TMR_OFF_CTRL, 32'h501, '1, `TMR_RESP_OKAY);
    repeat (4) @(posedge clk);
    check("readsDone", 32'h0, expQ.size());
    report_and_stop();
  end
endmodule
